// ### rtl/pcdc_top.sv
// top of the channel divider control: APB registers, dividers, routes
//
// Overview of operation
// - low phase lasts low count plus one
// - high phase lasts high count plus one
// - bypass powers divider down, passes input
// - sync ignore bit drops chip sync
// - force high only with sync ignore
// - start polarity picks first divided level
// - four-bit phase offset delays divider start
// - direct route picks oscillator or external
// - duty correction on unless disable bit set
// - each divider feeds only its pair
// - divider 1 fields at three fixed registers
//
// Local design decision: the APB interface to the registers.
module pcdc_top (
   input  wire logic        CLK_I,
   input  wire logic        RESET_N_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [11:0] PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   input  wire logic        SYNC_I,
   input  wire logic [1:0]  SRC_SEL_I,
   input  wire logic        OSC_LEVEL_I,
   input  wire logic        EXT_LEVEL_I,
   output logic             PAIR0_CLK_P_O,
   output logic             PAIR0_CLK_N_O,
   output logic             PAIR1_CLK_P_O,
   output logic             PAIR1_CLK_N_O,
   output logic             PAIR0_DUTY_CORR_ON_O,
   output logic             PAIR1_DUTY_CORR_ON_O,
   output logic             PAIR0_DIV_PWRDN_O,
   output logic             PAIR1_DIV_PWRDN_O
);
   ////////////////////////////////////////////////////////////////////
   // address map

   localparam logic [11:0] A_DIV0_ROUTE =
      {1'b0, pcdc_pkg::IDX_DIV0_ROUTE, 2'b00};
   localparam logic [11:0] A_DIV1_COUNTS =
      {1'b0, pcdc_pkg::IDX_DIV1_COUNTS, 2'b00};
   localparam logic [11:0] A_DIV1_MODE =
      {1'b0, pcdc_pkg::IDX_DIV1_MODE, 2'b00};
   localparam logic [11:0] A_DIV1_ROUTE =
      {1'b0, pcdc_pkg::IDX_DIV1_ROUTE, 2'b00};
   localparam logic [11:0] A_DIV2_COUNTS =
      {1'b0, pcdc_pkg::IDX_DIV2_COUNTS, 2'b00};
   localparam logic [11:0] A_STATUS =
      {1'b0, pcdc_pkg::IDX_STATUS, 2'b00};
   localparam int unsigned CW = pcdc_pkg::CNT_W;

   ////////////////////////////////////////////////////////////////////
   // declarations

   logic [7:0]    div0_route;
   logic [7:0]    div1_counts;
   logic [7:0]    div1_mode;
   logic [7:0]    div1_route;
   logic [7:0]    div2_counts;
   logic [7:0]    status;
   logic [7:0]    rd_mux;
   logic          mapped;
   logic          setup_ph;
   logic          wr_go;
   logic          div0_out;
   logic          div1_out;
   logic          div0_run;
   logic          div1_run;

   ////////////////////////////////////////////////////////////////////
   // APB slave

   // a request is answered in the first cycle of its access phase
   assign setup_ph = PSEL_I & ~PENABLE_I;
   // writes land only on the completing edge
   assign wr_go = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;

   // read decode; unmapped addresses answer with an error
   always_comb
   begin
      rd_mux = 8'h00;
      mapped = 1'b1;
      case (PADDR_I)
         A_DIV0_ROUTE:  rd_mux = div0_route;
         A_DIV1_COUNTS: rd_mux = div1_counts;
         A_DIV1_MODE:   rd_mux = div1_mode;
         A_DIV1_ROUTE:  rd_mux = div1_route;
         A_DIV2_COUNTS: rd_mux = div2_counts;
         A_STATUS:      rd_mux = status;
         default:       mapped = 1'b0;
      endcase
   end

   // answer flops: ready, error and read data sampled at setup
   always_ff @(posedge CLK_I)
   begin
      if (!RESET_N_I)
      begin
         PREADY_O  <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O  <= 32'h0000_0000;
      end
      else
      begin
         PREADY_O  <= setup_ph;
         PSLVERR_O <= setup_ph & ~mapped;
         if (setup_ph)
            PRDATA_O <= PWRITE_I ? 32'h0000_0000 : {24'h00_0000, rd_mux};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // registers

   // routing registers keep only their two defined bits
   always_ff @(posedge CLK_I)
   begin
      if (!RESET_N_I)
      begin
         div0_route <= pcdc_pkg::RST_ROUTE;
         div1_route <= pcdc_pkg::RST_ROUTE;
      end
      else if (wr_go)
      begin
         if (PADDR_I == A_DIV0_ROUTE)
            div0_route <= PWDATA_I[7:0] & pcdc_pkg::ROUTE_MASK;
         if (PADDR_I == A_DIV1_ROUTE)
            div1_route <= PWDATA_I[7:0] & pcdc_pkg::ROUTE_MASK;
      end
   end

   // count and mode registers; every bit is defined
   always_ff @(posedge CLK_I)
   begin
      if (!RESET_N_I)
      begin
         div1_counts <= pcdc_pkg::RST_DIV1_COUNTS;
         div1_mode   <= pcdc_pkg::RST_DIV1_MODE;
         div2_counts <= pcdc_pkg::RST_DIV2_COUNTS;
      end
      else if (wr_go)
      begin
         if (PADDR_I == A_DIV1_COUNTS)
            div1_counts <= PWDATA_I[7:0];
         if (PADDR_I == A_DIV1_MODE)
            div1_mode <= PWDATA_I[7:0];
         if (PADDR_I == A_DIV2_COUNTS)
            div2_counts <= PWDATA_I[7:0];
      end
   end

   // live status; divider 2 is stored only, its divider is elsewhere
   assign status = {2'b00, SRC_SEL_I, div1_run, div0_run,
                    PAIR1_CLK_P_O, PAIR0_CLK_P_O};

   ////////////////////////////////////////////////////////////////////
   // dividers

   // divider 0 runs at its fixed defaults, so it sits in bypass
   pcdc_divider #(
      .CNT_W (CW)
   ) u_div0 (
      .clk_i        (CLK_I),
      .rst_n_i      (RESET_N_I),
      .low_cnt_i    (pcdc_pkg::DIV0_COUNTS[pcdc_pkg::LOW_LSB +: CW]),
      .high_cnt_i   (pcdc_pkg::DIV0_COUNTS[pcdc_pkg::HIGH_LSB +: CW]),
      .phase_i      (pcdc_pkg::DIV0_MODE[pcdc_pkg::PHASE_LSB +: CW]),
      .bypass_i     (pcdc_pkg::DIV0_MODE[pcdc_pkg::BYPASS_BIT]),
      .nosync_i     (pcdc_pkg::DIV0_MODE[pcdc_pkg::NOSYNC_BIT]),
      .force_high_i (pcdc_pkg::DIV0_MODE[pcdc_pkg::FORCE_BIT]),
      .start_high_i (pcdc_pkg::DIV0_MODE[pcdc_pkg::START_BIT]),
      .sync_i       (SYNC_I),
      .out_o        (div0_out),
      .pwrdn_o      (PAIR0_DIV_PWRDN_O),
      .running_o    (div0_run)
   );

   // divider 1 is fully programmable
   pcdc_divider #(
      .CNT_W (CW)
   ) u_div1 (
      .clk_i        (CLK_I),
      .rst_n_i      (RESET_N_I),
      .low_cnt_i    (div1_counts[pcdc_pkg::LOW_LSB +: CW]),
      .high_cnt_i   (div1_counts[pcdc_pkg::HIGH_LSB +: CW]),
      .phase_i      (div1_mode[pcdc_pkg::PHASE_LSB +: CW]),
      .bypass_i     (div1_mode[pcdc_pkg::BYPASS_BIT]),
      .nosync_i     (div1_mode[pcdc_pkg::NOSYNC_BIT]),
      .force_high_i (div1_mode[pcdc_pkg::FORCE_BIT]),
      .start_high_i (div1_mode[pcdc_pkg::START_BIT]),
      .sync_i       (SYNC_I),
      .out_o        (div1_out),
      .pwrdn_o      (PAIR1_DIV_PWRDN_O),
      .running_o    (div1_run)
   );

   ////////////////////////////////////////////////////////////////////
   // output pairs: each route stage sees only its own divider

   pcdc_route u_pair0 (
      .clk_i     (CLK_I),
      .rst_n_i   (RESET_N_I),
      .div_i     (div0_out),
      .direct_i  (div0_route[pcdc_pkg::ROUTE_BIT]),
      .src_sel_i (SRC_SEL_I),
      .osc_i     (OSC_LEVEL_I),
      .ext_i     (EXT_LEVEL_I),
      .clk_p_o   (PAIR0_CLK_P_O),
      .clk_n_o   (PAIR0_CLK_N_O)
   );

   pcdc_route u_pair1 (
      .clk_i     (CLK_I),
      .rst_n_i   (RESET_N_I),
      .div_i     (div1_out),
      .direct_i  (div1_route[pcdc_pkg::ROUTE_BIT]),
      .src_sel_i (SRC_SEL_I),
      .osc_i     (OSC_LEVEL_I),
      .ext_i     (EXT_LEVEL_I),
      .clk_p_o   (PAIR1_CLK_P_O),
      .clk_n_o   (PAIR1_CLK_N_O)
   );

   // duty correction enables for the analog corrector, active high
   always_ff @(posedge CLK_I)
   begin
      if (!RESET_N_I)
      begin
         PAIR0_DUTY_CORR_ON_O <= 1'b1;
         PAIR1_DUTY_CORR_ON_O <= 1'b1;
      end
      else
      begin
         PAIR0_DUTY_CORR_ON_O <= ~div0_route[pcdc_pkg::DCC_BIT];
         PAIR1_DUTY_CORR_ON_O <= ~div1_route[pcdc_pkg::DCC_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks

   property p_counts_write;
      @(posedge CLK_I) disable iff (!RESET_N_I)
      (wr_go && PADDR_I == A_DIV1_COUNTS)
      |=> div1_counts == $past(PWDATA_I[7:0]);
   endproperty
   a_counts_write: assert property (p_counts_write)
      else $error("divider 1 counts not written");

   property p_mode_write;
      @(posedge CLK_I) disable iff (!RESET_N_I)
      (wr_go && PADDR_I == A_DIV1_MODE)
      |=> div1_mode == $past(PWDATA_I[7:0]);
   endproperty
   a_mode_write: assert property (p_mode_write)
      else $error("divider 1 mode not written");

   property p_own_pair;
      @(posedge CLK_I) disable iff (!RESET_N_I)
      !div1_route[pcdc_pkg::ROUTE_BIT]
      |=> PAIR1_CLK_P_O == $past(div1_out);
   endproperty
   a_own_pair: assert property (p_own_pair)
      else $error("pair 1 not fed by divider 1");

   property p_dcc;
      @(posedge CLK_I) disable iff (!RESET_N_I)
      $changed(div1_route[pcdc_pkg::DCC_BIT])
      |=> PAIR1_DUTY_CORR_ON_O == !$past(div1_route[pcdc_pkg::DCC_BIT]);
   endproperty
   a_dcc: assert property (p_dcc)
      else $error("duty correction enable wrong");

   property p_answer;
      @(posedge CLK_I) disable iff (!RESET_N_I)
      setup_ph |=> PREADY_O && PSLVERR_O == !$past(mapped);
   endproperty
   a_answer: assert property (p_answer)
      else $error("APB answer missing in access phase");

   property p_own_pair0;
      @(posedge CLK_I) disable iff (!RESET_N_I)
      !div0_route[pcdc_pkg::ROUTE_BIT]
      |=> PAIR0_CLK_P_O == $past(div0_out);
   endproperty
   a_own_pair0: assert property (p_own_pair0)
      else $error("pair 0 not fed by divider 0");

   property p_pair1_n;
      @(posedge CLK_I) disable iff (!RESET_N_I)
      !div1_route[pcdc_pkg::ROUTE_BIT]
      |=> PAIR1_CLK_N_O == !$past(div1_out);
   endproperty
   a_pair1_n: assert property (p_pair1_n)
      else $error("pair 1 complement not from divider 1");

   property p_route_write;
      @(posedge CLK_I) disable iff (!RESET_N_I)
      (wr_go && PADDR_I == A_DIV1_ROUTE)
      |=> div1_route == ($past(PWDATA_I[7:0]) & pcdc_pkg::ROUTE_MASK);
   endproperty
   a_route_write: assert property (p_route_write)
      else $error("divider 1 route not written");

   property p_dcc0;
      @(posedge CLK_I) disable iff (!RESET_N_I)
      1'b1 |=> PAIR0_DUTY_CORR_ON_O
               == !$past(div0_route[pcdc_pkg::DCC_BIT]);
   endproperty
   a_dcc0: assert property (p_dcc0)
      else $error("pair 0 duty correction enable wrong");

   property p_pwrdn1;
      @(posedge CLK_I) disable iff (!RESET_N_I)
      1'b1 |=> PAIR1_DIV_PWRDN_O == $past(div1_mode[pcdc_pkg::BYPASS_BIT]);
   endproperty
   a_pwrdn1: assert property (p_pwrdn1)
      else $error("divider 1 power down not following bypass");

   property p_err_no_write;
      @(posedge CLK_I) disable iff (!RESET_N_I)
      (PSEL_I && PENABLE_I && PREADY_O && PSLVERR_O)
      |=> $stable(div1_counts) && $stable(div1_mode)
          && $stable(div1_route) && $stable(div0_route);
   endproperty
   a_err_no_write: assert property (p_err_no_write)
      else $error("refused write changed a register");

   property p_mode_read;
      @(posedge CLK_I) disable iff (!RESET_N_I)
      (setup_ph && !PWRITE_I && PADDR_I == A_DIV1_MODE)
      |=> PRDATA_O == {24'h00_0000, $past(div1_mode)};
   endproperty
   a_mode_read: assert property (p_mode_read)
      else $error("divider 1 mode read back wrong");

   property p_ready_pulse;
      @(posedge CLK_I) disable iff (!RESET_N_I)
      PREADY_O |=> !PREADY_O;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("APB ready held longer than one cycle");
endmodule

// ### common/pcdc_pkg.sv
// package: register map, field layout, reset values and divider states
package pcdc_pkg;
   localparam int unsigned PADDR_W = 12;
   localparam int unsigned CNT_W   = 4;
   // register indices; the byte address is four times the index
   localparam logic [8:0] IDX_DIV0_ROUTE  = 9'h192;
   localparam logic [8:0] IDX_DIV1_COUNTS = 9'h193;
   localparam logic [8:0] IDX_DIV1_MODE   = 9'h194;
   localparam logic [8:0] IDX_DIV1_ROUTE  = 9'h195;
   localparam logic [8:0] IDX_DIV2_COUNTS = 9'h196;
   localparam logic [8:0] IDX_STATUS      = 9'h19F;
   // field positions
   localparam int unsigned LOW_LSB    = 4;
   localparam int unsigned HIGH_LSB   = 0;
   localparam int unsigned BYPASS_BIT = 7;
   localparam int unsigned NOSYNC_BIT = 6;
   localparam int unsigned FORCE_BIT  = 5;
   localparam int unsigned START_BIT  = 4;
   localparam int unsigned PHASE_LSB  = 0;
   localparam int unsigned ROUTE_BIT  = 1;
   localparam int unsigned DCC_BIT    = 0;
   // writable bits of the routing registers
   localparam logic [7:0] ROUTE_MASK = 8'h03;
   // values after reset
   localparam logic [7:0] RST_DIV1_COUNTS = 8'h00;
   localparam logic [7:0] RST_DIV1_MODE   = 8'h00;
   localparam logic [7:0] RST_ROUTE       = 8'h00;
   localparam logic [7:0] RST_DIV2_COUNTS = 8'h00;
   // divider 0 counts and mode are not programmable here
   localparam logic [7:0] DIV0_COUNTS = 8'h00;
   localparam logic [7:0] DIV0_MODE   = 8'h80;
   // source select codes for the direct route
   localparam logic [1:0] SRC_EXT = 2'h0;
   localparam logic [1:0] SRC_OSC = 2'h2;
   typedef enum logic [1:0] {DIV_HOLD, DIV_DELAY, DIV_RUN} pcdc_div_state_t;
endpackage

// ### rtl/pcdc_divider.sv
// one channel divider: low/high counts, phase delay, sync, force
module pcdc_divider #(
   parameter int CNT_W = 4
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic [CNT_W-1:0] low_cnt_i,
   input  wire logic [CNT_W-1:0] high_cnt_i,
   input  wire logic [CNT_W-1:0] phase_i,
   input  wire logic             bypass_i,
   input  wire logic             nosync_i,
   input  wire logic             force_high_i,
   input  wire logic             start_high_i,
   input  wire logic             sync_i,
   output logic                  out_o,
   output logic                  pwrdn_o,
   output logic                  running_o
);
   if (CNT_W < 1 || CNT_W > 8)
   begin : g_chk
      $error("pcdc_divider: CNT_W out of range");
   end

   pcdc_pkg::pcdc_div_state_t state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] phase_left;
   logic [CNT_W-1:0] dly_len;
   logic [CNT_W-1:0] phase_q;
   logic             level;
   logic             hold;
   logic             force_act;
   logic [CNT_W-1:0] limit;

   assign hold      = sync_i & ~nosync_i;
   assign force_act = nosync_i & force_high_i;
   assign limit     = level ? high_cnt_i : low_cnt_i;

   // sequencing: hold under sync, phase delay, then free run
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         state      <= pcdc_pkg::DIV_HOLD;
         phase_left <= '0;
      end
      else if (hold)
         state <= pcdc_pkg::DIV_HOLD;
      else
         case (state)
            pcdc_pkg::DIV_HOLD:
            begin
               phase_left <= phase_i;
               state <= (phase_i == '0) ? pcdc_pkg::DIV_RUN
                                        : pcdc_pkg::DIV_DELAY;
            end
            pcdc_pkg::DIV_DELAY:
            begin
               phase_left <= phase_left - 1'b1;
               if (phase_left == 1'b1)
                  state <= pcdc_pkg::DIV_RUN;
            end
            pcdc_pkg::DIV_RUN: ;
            default: state <= pcdc_pkg::DIV_HOLD;
         endcase
   end

   // output phase counter; >= recovers if a count shrinks mid-phase
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         level <= 1'b0;
         cnt   <= '0;
      end
      else if (hold || state == pcdc_pkg::DIV_HOLD)
      begin
         level <= start_high_i;
         cnt   <= '0;
      end
      else if (state == pcdc_pkg::DIV_RUN)
      begin
         if (bypass_i)
            level <= ~level;
         else if (cnt >= limit)
         begin
            level <= ~level;
            cnt   <= '0;
         end
         else
            cnt <= cnt + 1'b1;
      end
   end

   // registered outputs; forcing only applies when sync is ignored
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         out_o     <= 1'b0;
         pwrdn_o   <= 1'b0;
         running_o <= 1'b0;
      end
      else
      begin
         out_o     <= force_act ? 1'b1 : level;
         pwrdn_o   <= bypass_i;
         running_o <= (state == pcdc_pkg::DIV_RUN);
      end
   end

   // helper: length of the last phase delay
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i || state == pcdc_pkg::DIV_HOLD)
      begin
         dly_len <= '0;
         phase_q <= phase_i;
      end
      else if (state == pcdc_pkg::DIV_DELAY)
         dly_len <= dly_len + 1'b1;
   end

   property p_low_end;
      @(posedge clk_i) disable iff (!rst_n_i)
      (state == pcdc_pkg::DIV_RUN && !hold && !bypass_i && !level
       && cnt == low_cnt_i) |=> level;
   endproperty
   a_low_end: assert property (p_low_end)
      else $error("low phase did not end");

   property p_high_end;
      @(posedge clk_i) disable iff (!rst_n_i)
      (state == pcdc_pkg::DIV_RUN && !hold && !bypass_i && level
       && cnt == high_cnt_i) |=> !level;
   endproperty
   a_high_end: assert property (p_high_end)
      else $error("high phase did not end");

   property p_bypass;
      @(posedge clk_i) disable iff (!rst_n_i)
      (state == pcdc_pkg::DIV_RUN && !hold && bypass_i)
      |=> level != $past(level) && pwrdn_o;
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("bypass did not pass input");

   property p_hold;
      @(posedge clk_i) disable iff (!rst_n_i)
      hold |=> (state == pcdc_pkg::DIV_HOLD
                && level == $past(start_high_i));
   endproperty
   a_hold: assert property (p_hold)
      else $error("sync did not hold divider");

   property p_force;
      @(posedge clk_i) disable iff (!rst_n_i)
      force_act |=> out_o;
   endproperty
   a_force: assert property (p_force)
      else $error("force high not applied");

   property p_phase;
      @(posedge clk_i) disable iff (!rst_n_i)
      (state == pcdc_pkg::DIV_RUN
       && $past(state) != pcdc_pkg::DIV_RUN) |-> dly_len == phase_q;
   endproperty
   a_phase: assert property (p_phase)
      else $error("phase delay length wrong");
endmodule

// ### rtl/pcdc_route.sv
// output pair stage: divider or direct oscillator/external route
module pcdc_route (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       div_i,
   input  wire logic       direct_i,
   input  wire logic [1:0] src_sel_i,
   input  wire logic       osc_i,
   input  wire logic       ext_i,
   output logic            clk_p_o,
   output logic            clk_n_o
);
   logic pick;

   // source code 01 and 11 leave the pair on its divider
   always_comb
   begin
      pick = div_i;
      if (direct_i)
         case (src_sel_i)
            pcdc_pkg::SRC_OSC: pick = osc_i;
            pcdc_pkg::SRC_EXT: pick = ext_i;
            default:           pick = div_i;
         endcase
   end

   // complementary pair, both from flops
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         clk_p_o <= 1'b0;
         clk_n_o <= 1'b1;
      end
      else
      begin
         clk_p_o <= pick;
         clk_n_o <= ~pick;
      end
   end

   property p_osc_route;
      @(posedge clk_i) disable iff (!rst_n_i)
      (direct_i && src_sel_i == pcdc_pkg::SRC_OSC)
      |=> (clk_p_o == $past(osc_i) && clk_n_o == !$past(osc_i));
   endproperty
   a_osc_route: assert property (p_osc_route)
      else $error("oscillator not routed to pair");
endmodule

// ### dv/tb_pecl_channel_divider_ctl.sv
// self-checking bench for the channel divider control block
module tb_pecl_channel_divider_ctl;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {logic wr; logic [31:0] d; logic e;} pcdc_note_t;
   localparam logic [11:0] a_route0 = {1'b0, pcdc_pkg::IDX_DIV0_ROUTE, 2'b00};
   localparam logic [11:0] a_cnt1 = {1'b0, pcdc_pkg::IDX_DIV1_COUNTS, 2'b00};
   localparam logic [11:0] a_mode1 = {1'b0, pcdc_pkg::IDX_DIV1_MODE, 2'b00};
   localparam logic [11:0] a_route1 = {1'b0, pcdc_pkg::IDX_DIV1_ROUTE, 2'b00};
   localparam logic [11:0] a_cnt2 = {1'b0, pcdc_pkg::IDX_DIV2_COUNTS, 2'b00};
   // unmapped word just past the divider 2 counts
   localparam logic [11:0] a_bad = 12'h65C;
   logic        CLK_I = 1'b0, RESET_N_I = 1'b0, SYNC_I = 1'b0;
   logic        PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
   logic [11:0] PADDR_I = 12'h000;
   logic [31:0] PWDATA_I = 32'h0000_0000;
   logic [1:0]  SRC_SEL_I = 2'h0;
   logic        OSC_LEVEL_I = 1'b0, EXT_LEVEL_I = 1'b0;
   logic [31:0] PRDATA_O;
   logic        PREADY_O, PSLVERR_O, P0P, P0N, P1P, P1N, DC0, DC1, PD0, PD1;
   int          fails = 0;
   int          compares = 0;
   int          cycles = 0;
   pcdc_note_t  notes[$];
   pcdc_note_t  note;

   pcdc_top u_dut (
      .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .PSEL_I(PSEL_I),
      .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
      .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
      .PSLVERR_O(PSLVERR_O), .SYNC_I(SYNC_I), .SRC_SEL_I(SRC_SEL_I),
      .OSC_LEVEL_I(OSC_LEVEL_I), .EXT_LEVEL_I(EXT_LEVEL_I),
      .PAIR0_CLK_P_O(P0P), .PAIR0_CLK_N_O(P0N), .PAIR1_CLK_P_O(P1P),
      .PAIR1_CLK_N_O(P1N), .PAIR0_DUTY_CORR_ON_O(DC0),
      .PAIR1_DUTY_CORR_ON_O(DC1), .PAIR0_DIV_PWRDN_O(PD0),
      .PAIR1_DIV_PWRDN_O(PD1)
   );

   // 100 MHz clock
   always #5 CLK_I = ~CLK_I;

   ////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [31:0] w1(input logic x);
      return {31'h0, x};
   endfunction

   // note first, then hold setup and access until pready is sampled
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] wd, input logic [31:0] ed,
                      input logic ee);
      notes.push_back('{w, ed, ee});
      @(posedge CLK_I);
      PSEL_I    <= 1'b1;
      PENABLE_I <= 1'b0;
      PWRITE_I  <= w;
      PADDR_I   <= a;
      PWDATA_I  <= wd;
      @(posedge CLK_I);
      PENABLE_I <= 1'b1;
      do
         @(posedge CLK_I);
      while (PREADY_O !== 1'b1);
      PSEL_I    <= 1'b0;
      PENABLE_I <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d}, 32'h0, 1'b0);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                     input logic ee);
      apb(1'b0, a, 32'h0, ed, ee);
   endtask

   task automatic step(inout int n);
      @(posedge CLK_I);
      n++;
   endtask

   function automatic logic pl(input logic p0);
      return p0 ? P0P : P1P;
   endfunction

   // skip a partial phase, then count one whole high and low phase
   task automatic phases(input logic p0, input int hi, input int lo);
      int n, h, l;
      n = 0;
      h = 0;
      l = 0;
      repeat (4) @(posedge CLK_I);
      while (pl(p0) !== 1'b0 && n < 99) step(n);
      while (pl(p0) !== 1'b1 && n < 99) step(n);
      while (pl(p0) === 1'b1 && h < 99) step(h);
      while (pl(p0) === 1'b0 && l < 99) step(l);
      chk("high phase", hi, h);
      chk("low phase", lo, l);
      @(negedge CLK_I);
      chk("complement", w1(~pl(p0)), w1(p0 ? P0N : P1N));
   endtask

   // sync held, then edges from its release to the first level change
   task automatic sync_run(input logic lvl, output int d);
      @(posedge CLK_I);
      SYNC_I <= 1'b1;
      repeat (8) @(posedge CLK_I);
      chk("held level", w1(lvl), w1(P1P));
      SYNC_I <= 1'b0;
      d = 0;
      step(d);
      while (P1P === lvl && d < 99) step(d);
   endtask

   // other source gets the inverse so a wrong choice shows
   task automatic follow(input logic p0, input logic ext);
      logic v, prev;
      prev = 1'b0;
      for (int i = 0; i < 12; i++)
      begin
         v = 1'($urandom());
         @(posedge CLK_I);
         OSC_LEVEL_I <= v ^ ext;
         EXT_LEVEL_I <= v ^ ~ext;
         @(negedge CLK_I);
         if (i > 0) chk("direct route", w1(prev), w1(pl(p0)));
         prev = v;
      end
   endtask

   ////////////////////////////////////////////////////////////
   // result watcher: each completed transfer takes the oldest note
   always @(posedge CLK_I)
   begin
      if (PSEL_I && PENABLE_I && PREADY_O === 1'b1)
      begin
         note = notes.pop_front();
         chk("pslverr", w1(note.e), w1(PSLVERR_O));
         if (!note.wr) chk("prdata", note.d, PRDATA_O);
      end
   end

   // hang guard, well above the several hundred cycles the run needs
   always @(posedge CLK_I)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         tally_and_finish();
      end
   end

   initial
   begin
      logic [7:0]  r;
      logic [7:0]  tab[6];
      logic [11:0] rw[3];
      int          d0, d1, d2, n;
      tab = '{8'h00, 8'h11, 8'hF0, 8'h0F, 8'hFF, 8'h00};
      rw = '{a_cnt1, a_mode1, a_cnt2};
      n = 0;
      void'($urandom(32'h1219948D));
      repeat (10) @(posedge CLK_I);
      RESET_N_I <= 1'b1;
      repeat (3) @(posedge CLK_I);
      chk("pwrdn0", 32'h1, w1(PD0));
      chk("pwrdn1", 32'h0, w1(PD1));
      chk("dcc0", 32'h1, w1(DC0));
      chk("dcc1", 32'h1, w1(DC1));
      rd(a_route0, 32'h0, 1'b0);
      rd(a_cnt1, 32'h0, 1'b0);
      rd(a_mode1, 32'h0, 1'b0);
      rd(a_route1, 32'h0, 1'b0);
      rd(a_cnt2, 32'h0, 1'b0);
      rd(a_bad, 32'h0, 1'b1);
      apb(1'b1, a_bad, 32'hFF, 32'h0, 1'b1);
      wr(a_route1, 8'hFF);
      rd(a_route1, 32'h3, 1'b0);
      wr(a_route1, 8'h00);
      foreach (rw[i])
      begin
         r = 8'($urandom());
         wr(rw[i], r);
         rd(rw[i], {24'h0, r}, 1'b0);
      end
      // count table, one random entry, with divider 1 free running
      wr(a_mode1, 8'h00);
      foreach (tab[i])
      begin
         r = (i == 5) ? 8'($urandom()) : tab[i];
         wr(a_cnt1, r);
         phases(1'b0, r[3:0] + 1, r[7:4] + 1);
      end
      wr(a_cnt1, 8'h55);
      wr(a_mode1, 8'h80);
      phases(1'b0, 1, 1);
      chk("pwrdn1", 32'h1, w1(PD1));
      // low phase 4 cycles, high phase 3 cycles
      wr(a_cnt1, 8'h32);
      wr(a_mode1, 8'h00);
      sync_run(1'b0, d0);
      wr(a_mode1, 8'h0F);
      sync_run(1'b0, d1);
      chk("phase delay", 32'd15, d1 - d0);
      wr(a_mode1, 8'h10);
      sync_run(1'b1, d2);
      chk("start high", 32'd1, d0 - d2);
      wr(a_mode1, 8'h40);
      SYNC_I <= 1'b1;
      phases(1'b0, 3, 4);
      @(posedge CLK_I);
      SYNC_I <= 1'b0;
      wr(a_mode1, 8'h20);
      phases(1'b0, 3, 4);
      wr(a_mode1, 8'h60);
      repeat (4) @(posedge CLK_I);
      for (int i = 0; i < 20; i++)
      begin
         @(posedge CLK_I);
         n += int'(P1P === 1'b1);
      end
      chk("forced high", 32'd20, n);
      // direct routes on pair 1, then pair 0; pair 0 stays on its bypassed divider until its turn
      wr(a_mode1, 8'h00);
      wr(a_cnt1, 8'h11);
      wr(a_route1, 8'h02);
      SRC_SEL_I <= 2'h2;
      follow(1'b0, 1'b0);
      @(posedge CLK_I);
      SRC_SEL_I <= 2'h0;
      follow(1'b0, 1'b1);
      phases(1'b1, 1, 1);
      @(posedge CLK_I);
      SRC_SEL_I <= 2'h1;
      phases(1'b0, 2, 2);
      wr(a_route1, 8'h00);
      wr(a_route0, 8'h02);
      SRC_SEL_I <= 2'h2;
      follow(1'b1, 1'b0);
      phases(1'b0, 2, 2);
      wr(a_route0, 8'h01);
      repeat (2) @(posedge CLK_I);
      chk("dcc0", 32'h0, w1(DC0));
      chk("dcc1", 32'h1, w1(DC1));
      wr(a_route1, 8'h01);
      wr(a_route0, 8'h00);
      repeat (2) @(posedge CLK_I);
      chk("dcc0", 32'h1, w1(DC0));
      chk("dcc1", 32'h0, w1(DC1));
      chk("notes left", 32'h0, notes.size());
      tally_and_finish();
   end
endmodule
